// ===== design/position_unit_scaling.sv
`default_nettype none
// Overview of operation
// - Converts positions from user units to internal units and back; values kept in user units.
// - After reset the ratio is one revolution per 16384 user units.
// - Ratio equals top value in revolutions over bottom value in user units.
// - Writing top activates the ratio; a bottom write alone only stays pending.
// - Top is signed 32-bit, accepted from 1 to 2147483647, reset to one.
// - Bottom is signed 32-bit in user units, accepted from 1 to 2147483647.
// - Ratio writes are refused while the power amplifier is enabled.
// - With amplifier enabled, user values convert to internal units with the active ratio.
// - Internal resolution is 131072 positions per revolution.
// - Granularity equals internal resolution divided by user units per revolution.
// - At 4096 user units per revolution each user step is 32 internal positions.
module position_unit_scaling
  import scaling_pkg::*;
(
  // Clock, reset and enable
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Power stage state
  input wire logic i_amp_enabled,
  // Parameter access
  input wire par_req_t i_par,
  output logic o_par_ack,
  output logic o_par_err,
  output logic [31:0] o_par_rdata,
  // Conversion requests
  input wire logic i_conv_req,
  input wire conv_req_t i_conv,
  output logic o_conv_ready,
  output logic o_conv_done,
  output logic o_conv_ovf,
  output logic [31:0] o_conv_result,
  // Ratio status
  output logic [31:0] o_active_top,
  output logic [31:0] o_active_bottom,
  output logic o_ratio_pending
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic in_range(input logic [31:0] v);
    in_range = !v[31] && (v >= RATIO_MIN) && (v <= RATIO_MAX);
  endfunction

  function automatic logic [32:0] saturate(input logic [DIVIDEND_W-1:0] q, input logic neg);
    logic [32:0] lim;
    logic [31:0] mag;
    lim = neg ? NEG_LIMIT : POS_LIMIT;
    mag = (q > {63'h0, lim}) ? lim[31:0] : q[31:0];
    saturate = {(q > {63'h0, lim}), neg ? 32'(-mag) : mag};
  endfunction

  // ****************************************************************
  // Parameter registers
  // ****************************************************************
  logic [31:0] active_top, next_active_top;
  logic [31:0] active_bottom, next_active_bottom;
  logic [31:0] pend_bottom, next_pend_bottom;
  logic pending, next_pending;
  logic par_ack, next_par_ack;
  logic par_err, next_par_err;
  logic [31:0] par_rdata, next_par_rdata;
  logic sel_top, sel_bottom, wr_ok, top_wr_ok, bottom_wr_ok;

  always_comb
  begin
    sel_top = (i_par.addr == ADDR_RATIO_TOP);
    sel_bottom = (i_par.addr == ADDR_RATIO_BOTTOM);
    wr_ok = i_par.wr && !i_amp_enabled && in_range(i_par.wdata);
    top_wr_ok = wr_ok && sel_top;
    bottom_wr_ok = wr_ok && sel_bottom;
    next_active_top = active_top;
    next_active_bottom = active_bottom;
    next_pend_bottom = pend_bottom;
    next_pending = pending;
    next_par_ack = i_par.wr || i_par.rd;
    next_par_err = (i_par.wr || i_par.rd) && !(sel_top || sel_bottom);
    next_par_rdata = par_rdata;
    if (i_par.wr && (sel_top || sel_bottom) && !wr_ok)
    begin
      next_par_err = 1'b1;
    end
    if (bottom_wr_ok)
    begin
      next_pend_bottom = i_par.wdata;
      next_pending = 1'b1;
    end
    if (top_wr_ok)
    begin
      next_active_top = i_par.wdata;
      next_active_bottom = pend_bottom;
      next_pending = 1'b0;
    end
    if (i_par.rd)
    begin
      next_par_rdata = sel_top ? active_top : (sel_bottom ? pend_bottom : 32'h0000_0000);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      active_top <= RATIO_TOP_RST;
      active_bottom <= RATIO_BOTTOM_RST;
      pend_bottom <= RATIO_BOTTOM_RST;
      pending <= 1'b0;
      par_ack <= 1'b0;
      par_err <= 1'b0;
      par_rdata <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      active_top <= next_active_top;
      active_bottom <= next_active_bottom;
      pend_bottom <= next_pend_bottom;
      pending <= next_pending;
      par_ack <= next_par_ack;
      par_err <= next_par_err;
      par_rdata <= next_par_rdata;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  // Operands are latched at the request, so a ratio change mid-way does not
  // mix two ratios inside one result.
  conv_state_t state, next_state;
  conv_dir_t dir, next_dir;
  logic neg, next_neg;
  logic [31:0] mag, next_mag;
  logic [31:0] op_top, next_op_top;
  logic [31:0] op_bottom, next_op_bottom;
  logic done, next_done;
  logic ovf, next_ovf;
  logic [31:0] result, next_result;
  logic [DIVIDEND_W-1:0] dividend;
  logic [DIVISOR_W-1:0] divisor;
  logic [DIVIDEND_W-1:0] quotient;
  logic [32:0] sat;
  logic div_done;

  always_comb
  begin
    if (dir == DIR_USER_TO_INTERNAL)
    begin
      // The product is widened first: a 32-bit product would wrap for large ratios.
      divisor = {32'h0, op_bottom};
      dividend = {15'h0, 64'(mag) * 64'(op_top), 17'h0};
    end
    else
    begin
      divisor = {15'h0, op_top, 17'h0};
      dividend = {32'h0, 64'(mag) * 64'(op_bottom)};
    end
    dividend = dividend + {32'h0, 1'b0, divisor[DIVISOR_W-1:1]};
    sat = saturate(quotient, neg);
    next_state = state;
    next_dir = dir;
    next_neg = neg;
    next_mag = mag;
    next_op_top = op_top;
    next_op_bottom = op_bottom;
    next_done = 1'b0;
    next_ovf = ovf;
    next_result = result;
    case (state)
      ST_IDLE:
      begin
        if (i_conv_req)
        begin
          next_dir = i_conv.dir;
          next_neg = i_conv.value[31];
          next_mag = i_conv.value[31] ? 32'(-i_conv.value) : i_conv.value;
          next_op_top = active_top;
          next_op_bottom = active_bottom;
          next_state = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (div_done)
        begin
          next_state = ST_FIN;
        end
      end
      ST_FIN:
      begin
        next_result = sat[31:0];
        next_ovf = sat[32];
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      state <= ST_IDLE;
      dir <= DIR_USER_TO_INTERNAL;
      neg <= 1'b0;
      mag <= 32'h0000_0000;
      op_top <= RATIO_TOP_RST;
      op_bottom <= RATIO_BOTTOM_RST;
      done <= 1'b0;
      ovf <= 1'b0;
      result <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      state <= next_state;
      dir <= next_dir;
      neg <= next_neg;
      mag <= next_mag;
      op_top <= next_op_top;
      op_bottom <= next_op_bottom;
      done <= next_done;
      ovf <= next_ovf;
      result <= next_result;
    end
  end

  scale_divider u_divider (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_start(state == ST_LOAD),
    .i_dividend(dividend),
    .i_divisor(divisor),
    .o_busy(),
    .o_done(div_done),
    .o_quotient(quotient)
  );

  assign o_par_ack = par_ack;
  assign o_par_err = par_err;
  assign o_par_rdata = par_rdata;
  assign o_conv_ready = (state == ST_IDLE);
  assign o_conv_done = done;
  assign o_conv_ovf = ovf;
  assign o_conv_result = result;
  assign o_active_top = active_top;
  assign o_active_bottom = active_bottom;
  assign o_ratio_pending = pending;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_reset_default;
    @(posedge i_clk_sys) $past(i_sys_rst) && !i_sys_rst |->
      active_top == RATIO_TOP_RST && active_bottom == RATIO_BOTTOM_RST;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("ratio not at default after reset");

  property p_bottom_pending;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_ce && bottom_wr_ok |=> $stable(active_bottom) && $stable(active_top) && pending;
  endproperty
  a_bottom_pending: assert property (p_bottom_pending)
    else $error("bottom write changed the active ratio");

  property p_top_activates;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_ce && top_wr_ok |=> active_top == $past(i_par.wdata) &&
      active_bottom == $past(pend_bottom) && !pending;
  endproperty
  a_top_activates: assert property (p_top_activates)
    else $error("top write did not activate the ratio");

  property p_refuse_amp;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_ce && i_par.wr && (sel_top || sel_bottom) && i_amp_enabled |=>
      o_par_err && $stable(active_top) && $stable(active_bottom) && $stable(pend_bottom);
  endproperty
  a_refuse_amp: assert property (p_refuse_amp)
    else $error("ratio write accepted with amplifier enabled");

  property p_top_range;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_ce && i_par.wr && sel_top && (i_par.wdata[31] || i_par.wdata == 32'h0) |=>
      o_par_err && $stable(active_top);
  endproperty
  a_top_range: assert property (p_top_range)
    else $error("top value out of range accepted");

  property p_bottom_range;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_ce && i_par.wr && sel_bottom && (i_par.wdata[31] || i_par.wdata == 32'h0) |=>
      o_par_err && $stable(pend_bottom);
  endproperty
  a_bottom_range: assert property (p_bottom_range)
    else $error("bottom value out of range accepted");

  property p_conv_latency;
    @(posedge i_clk_sys) disable iff (i_sys_rst || !i_ce)
      o_conv_ready && i_conv_req |=> !o_conv_ready [*8] ##[91:100] o_conv_done;
  endproperty
  a_conv_latency: assert property (p_conv_latency)
    else $error("conversion did not finish in time");

  property p_done_pulse;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_conv_done && i_ce |=> !o_conv_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done held longer than one cycle");

endmodule // position_unit_scaling
`default_nettype wire

// ===== design/scaling_pkg.sv
`default_nettype none
package scaling_pkg;

  // ****************************************************************
  // Parameter addresses and reset values
  // ****************************************************************
  localparam logic [15:0] ADDR_RATIO_BOTTOM = 16'h060e;
  localparam logic [15:0] ADDR_RATIO_TOP = 16'h0610;
  localparam logic [31:0] RATIO_TOP_RST = 32'h0000_0001;
  localparam logic [31:0] RATIO_BOTTOM_RST = 32'h0000_4000;
  localparam logic [31:0] RATIO_MIN = 32'h0000_0001;
  localparam logic [31:0] RATIO_MAX = 32'h7fff_ffff;

  // ****************************************************************
  // Internal resolution and arithmetic widths
  // ****************************************************************
  localparam logic [31:0] INTERNAL_RES = 32'h0002_0000;
  localparam int RES_SHIFT = 17;
  localparam int DIVIDEND_W = 96;
  localparam int DIVISOR_W = 64;
  localparam logic [6:0] DIV_STEPS = 7'h60;
  localparam logic [32:0] POS_LIMIT = 33'h0_7fff_ffff;
  localparam logic [32:0] NEG_LIMIT = 33'h0_8000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {
    DIR_USER_TO_INTERNAL = 1'b0,
    DIR_INTERNAL_TO_USER = 1'b1
  } conv_dir_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b11,
    ST_FIN = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } par_req_t;

  typedef struct packed {
    conv_dir_t dir;
    logic [31:0] value;
  } conv_req_t;

endpackage
`default_nettype wire

// ===== design/scale_divider.sv
`default_nettype none
module scale_divider
  import scaling_pkg::*;
(
  // Clock, reset and enable
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Operands
  input wire logic i_start,
  input wire logic [DIVIDEND_W-1:0] i_dividend,
  input wire logic [DIVISOR_W-1:0] i_divisor,
  // Result
  output logic o_busy,
  output logic o_done,
  output logic [DIVIDEND_W-1:0] o_quotient
);

  // ****************************************************************
  // Restoring division, one quotient bit per cycle
  // ****************************************************************
  // A serial divider was traded for latency: a 96 by 64 bit array divider
  // would dominate the area of the whole block.
  logic [DIVIDEND_W-1:0] quo, next_quo;
  logic [DIVISOR_W-1:0] rem, next_rem;
  logic [DIVISOR_W-1:0] divisor, next_divisor;
  logic [6:0] count, next_count;
  logic busy, next_busy;
  logic done, next_done;
  logic [DIVISOR_W:0] trial;
  logic [DIVISOR_W+1:0] diff;

  always_comb
  begin
    trial = {rem, quo[DIVIDEND_W-1]};
    diff = {1'b0, trial} - {2'b00, divisor};
    next_quo = quo;
    next_rem = rem;
    next_divisor = divisor;
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (i_start && !busy)
    begin
      next_quo = i_dividend;
      next_rem = '0;
      next_divisor = i_divisor;
      next_count = DIV_STEPS;
      next_busy = 1'b1;
    end
    else if (busy)
    begin
      next_quo = {quo[DIVIDEND_W-2:0], !diff[DIVISOR_W+1]};
      next_rem = diff[DIVISOR_W+1] ? trial[DIVISOR_W-1:0] : diff[DIVISOR_W-1:0];
      next_count = count - 7'h01;
      if (count == 7'h01)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      quo <= '0;
      rem <= '0;
      divisor <= '0;
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (i_ce)
    begin
      quo <= next_quo;
      rem <= next_rem;
      divisor <= next_divisor;
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign o_busy = busy;
  assign o_done = done;
  assign o_quotient = quo;

endmodule // scale_divider
`default_nettype wire

// ===== tb/param_master.sv
`default_nettype none
module param_master
  import scaling_pkg::*;
(
  // Clock
  input wire logic i_clk_sys,
  // Parameter port
  output var par_req_t o_par,
  input wire logic i_par_ack,
  input wire logic i_par_err,
  input wire logic [31:0] i_par_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Configuring party
  // ****************************************************************
  // A stored user-unit value that must follow every ratio change.
  logic [31:0] soft_limit_positive;
  logic [31:0] last_top;
  logic [31:0] last_bottom;

  initial
  begin
    o_par = '0;
    soft_limit_positive = 32'h0001_0000;
    last_top = RATIO_TOP_RST;
    last_bottom = RATIO_BOTTOM_RST;
  end

  // The answer is taken in the cycle after the request.
  task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] data,
                        output logic [1:0] resp, output logic [31:0] rdata);
    @(negedge i_clk_sys);
    o_par = '{wr: wr, rd: !wr, addr: addr, wdata: data};
    @(negedge i_clk_sys);
    resp = {i_par_ack, i_par_err};
    rdata = i_par_rdata;
    // Released lines show the inverse so stale data is never taken for valid.
    o_par = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  task automatic set_ratio(input logic [31:0] bottom, input logic [31:0] top,
                           output logic [1:0] resp);
    logic [1:0] r0;
    logic [31:0] rd;
    logic [127:0] scaled;
    access(1'b1, ADDR_RATIO_BOTTOM, bottom, r0, rd);
    access(1'b1, ADDR_RATIO_TOP, top, resp, rd);
    resp = resp | r0;
    if (resp == 2'b10)
    begin
      scaled = 128'(soft_limit_positive) * last_top * bottom / (128'(last_bottom) * top);
      soft_limit_positive = scaled[31:0];
      last_top = top;
      last_bottom = bottom;
    end
  endtask
endmodule // param_master
`default_nettype wire

// ===== tb/position_unit_scaling_tb.sv
`default_nettype none
module position_unit_scaling_tb
  import scaling_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [31:0] bottom;
    logic [31:0] top;
    logic dir;
    logic [31:0] value;
    logic [31:0] result;
    logic ovf;
  } row_t;

  localparam row_t ROWS [11] = '{
    '{32'h4000, 32'h1, 1'b0, 32'h1, 32'h8, 1'b0},
    '{32'h2_0000, 32'h1, 1'b0, 32'h1, 32'h1, 1'b0},
    '{32'h1000, 32'h1, 1'b0, 32'h1, 32'h20, 1'b0},
    '{32'h457, 32'h3, 1'b0, 32'h384, 32'h4_dc49, 1'b0},
    '{32'hf570, 32'ha, 1'b1, 32'h2_0000, 32'h188b, 1'b0},
    '{32'h4_0000, 32'h1, 1'b0, 32'hffff_ffff, 32'hffff_ffff, 1'b0},
    '{32'h3, 32'h1, 1'b0, 32'hffff_ffff, 32'hffff_5555, 1'b0},
    '{32'h1, 32'h7fff_ffff, 1'b0, 32'h1, 32'h7fff_ffff, 1'b1},
    '{32'h1, 32'h1, 1'b0, 32'h8000_0000, 32'h8000_0000, 1'b1},
    '{32'h7fff_ffff, 32'h1, 1'b1, 32'h2_0000, 32'h7fff_ffff, 1'b0},
    '{32'h4000, 32'h1, 1'b1, 32'hffff_fff8, 32'hffff_ffff, 1'b0}
  };
  localparam logic [15:0] BAD_ADDR [5] = '{ADDR_RATIO_TOP, ADDR_RATIO_TOP,
    ADDR_RATIO_BOTTOM, ADDR_RATIO_BOTTOM, 16'h0612};
  localparam logic [31:0] BAD_DATA [5] = '{32'h0, 32'hffff_ffff, 32'h0, 32'h8000_0000, 32'h1};

  logic clk;
  logic rst;
  logic amp;
  logic ce;
  logic conv_req;
  conv_req_t conv;
  par_req_t par;
  logic par_ack, par_err, ratio_pending, conv_ready, conv_done, conv_ovf;
  logic [31:0] par_rdata, conv_result, active_top, active_bottom;
  logic [1:0] resp;
  logic [31:0] rd;
  int n_mismatch;
  int num_checks;

  position_unit_scaling i_dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_ce(ce), .i_amp_enabled(amp),
    .i_par(par), .o_par_ack(par_ack), .o_par_err(par_err), .o_par_rdata(par_rdata),
    .i_conv_req(conv_req), .i_conv(conv), .o_conv_ready(conv_ready),
    .o_conv_done(conv_done), .o_conv_ovf(conv_ovf), .o_conv_result(conv_result),
    .o_active_top(active_top), .o_active_bottom(active_bottom),
    .o_ratio_pending(ratio_pending));

  param_master i_master (.i_clk_sys(clk), .o_par(par), .i_par_ack(par_ack),
    .i_par_err(par_err), .i_par_rdata(par_rdata));

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic chk_word(input string name, input logic [31:0] expv, input logic [31:0] got);
    num_checks++;
    if (got !== expv)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, expv, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic expv, input logic got);
    num_checks++;
    if (got !== expv)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", name, expv, got);
    end
  endtask

  task automatic convert(input logic dir, input logic [31:0] value, input logic [31:0] expv,
                         input logic exp_ovf);
    int cycles;
    @(negedge clk);
    conv_req = 1'b1;
    conv = '{dir: conv_dir_t'(dir), value: value};
    @(negedge clk);
    conv_req = 1'b0;
    conv.value = ~value;
    // Counts edges after the taking one: load, the divider steps, its done and the finish.
    cycles = 0;
    chk_bit("ready", 1'b0, conv_ready);
    while (conv_done !== 1'b1 && cycles < 200)
    begin
      @(negedge clk);
      cycles++;
    end
    chk_word("latency", 32'(DIV_STEPS) + 32'h3, 32'(cycles));
    chk_word("result", expv, conv_result);
    chk_bit("ovf", exp_ovf, conv_ovf);
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // About sixteen hundred cycles are expected; this allows two and a half times that.
  initial
  begin
    #80000;
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    rst = 1'b1;
    amp = 1'b0;
    ce = 1'b1;
    conv_req = 1'b0;
    conv = '0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    foreach (ROWS[k])
    begin
      i_master.set_ratio(ROWS[k].bottom, ROWS[k].top, resp);
      chk_word("ratio_resp", 32'h2, 32'(resp));
      chk_word("active_top", ROWS[k].top, active_top);
      chk_word("active_bottom", ROWS[k].bottom, active_bottom);
      convert(ROWS[k].dir, ROWS[k].value, ROWS[k].result, ROWS[k].ovf);
    end
    // A bottom write alone must not touch the running ratio.
    i_master.access(1'b1, ADDR_RATIO_BOTTOM, 32'h1000, resp, rd);
    chk_bit("pending", 1'b1, ratio_pending);
    chk_word("active_bottom", 32'h4000, active_bottom);
    i_master.access(1'b0, ADDR_RATIO_BOTTOM, 32'h0, resp, rd);
    chk_word("bottom_read", 32'h1000, rd);
    convert(1'b0, 32'h1, 32'h8, 1'b0);
    i_master.access(1'b1, ADDR_RATIO_TOP, 32'h1, resp, rd);
    chk_bit("pending", 1'b0, ratio_pending);
    convert(1'b0, 32'h1, 32'h20, 1'b0);
    amp = 1'b1;
    i_master.access(1'b1, ADDR_RATIO_TOP, 32'h2, resp, rd);
    chk_word("amp_resp", 32'h3, 32'(resp));
    i_master.access(1'b1, ADDR_RATIO_BOTTOM, 32'h2_0000, resp, rd);
    chk_word("amp_resp", 32'h3, 32'(resp));
    chk_word("active_top", 32'h1, active_top);
    convert(1'b0, 32'h2, 32'h40, 1'b0);
    amp = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      i_master.access(1'b1, BAD_ADDR[k], BAD_DATA[k], resp, rd);
      chk_word("range_resp", 32'h3, 32'(resp));
    end
    chk_word("active_top", 32'h1, active_top);
    chk_word("active_bottom", 32'h1000, active_bottom);
    // A low clock enable must swallow a write whole; one idle edge lets the last ack drop.
    @(negedge clk);
    ce = 1'b0;
    i_master.access(1'b1, ADDR_RATIO_BOTTOM, 32'h10, resp, rd);
    ce = 1'b1;
    chk_word("frozen_resp", 32'h0, 32'(resp));
    chk_bit("pending", 1'b0, ratio_pending);
    i_master.access(1'b0, 16'h0612, 32'h0, resp, rd);
    chk_word("unmapped_read", 32'h0, rd);
    // A second reset in mid-run restores the default scaling.
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk_word("active_top", 32'h1, active_top);
    chk_word("active_bottom", 32'h4000, active_bottom);
    chk_bit("pending", 1'b0, ratio_pending);
    chk_bit("ready", 1'b1, conv_ready);
    i_master.access(1'b0, ADDR_RATIO_BOTTOM, 32'h0, resp, rd);
    chk_word("bottom_read", 32'h4000, rd);
    convert(1'b0, 32'h1, 32'h8, 1'b0);
    wrap_up();
  end
endmodule // position_unit_scaling_tb
`default_nettype wire
